// file: dcc_channel_config.sv
// per-channel configuration and byte mover of a seven-channel transfer engine
// assumes the bus, source and sink all run on ref_clk; a byte read
// requested by src_rd appears on src_data exactly one cycle later
`include "dcc_channel_config_regs.svh"
`default_nettype none
module dcc_channel_config #(
	parameter int NUM_CH = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [2:0] act_ch,
	input wire logic act_busy,
	input wire logic [9:0] act_size,
	input wire logic act_wrap,
	output logic src_rd,
	output logic src_from_ram,
	output logic [11:0] src_addr,
	output logic [3:0] src_route,
	input wire logic [7:0] src_data,
	output logic snk_valid,
	output logic [7:0] snk_data,
	output logic [11:0] snk_addr,
	output logic [1:0] snk_lane,
	output logic [3:0] snk_route,
	output logic snk_to_ram,
	input wire logic snk_ready,
	output logic full_irq,
	output logic mid_irq,
	output logic xfer_done,
	output logic stalled
);

	if (NUM_CH < 1 || NUM_CH > 7) begin : g_bad_num_ch
		$error("NUM_CH must lie between 1 and 7");
	end

	function automatic logic route_to_ram(input logic [3:0] r);
		return r == dcc_pkg::DCC_ENC_TO_RAM || r == dcc_pkg::DCC_SPI_TO_RAM ||
			r == dcc_pkg::DCC_AES_OUT_TO_RAM;
	endfunction

	function automatic logic [1:0] group_len(input logic [3:0] r);
		if (r == dcc_pkg::DCC_RAM_TO_ENC || r == dcc_pkg::DCC_ENC_TO_RAM) begin
			return `DCC_ENCODER_BYTES;
		end
		return 2'h1;
	endfunction

	function automatic dcc_pkg::dcc_addr_t addr_of(input logic [3:0] hi,
		input logic [7:0] lo, input dcc_pkg::dcc_offset_t ofs);
		return {hi, lo} + {2'h0, ofs};
	endfunction

	logic [7:0] cfg_r [NUM_CH];
	logic [7:0] cfg_nxt [NUM_CH];
	logic [7:0] bal_r [NUM_CH];
	logic [7:0] bal_nxt [NUM_CH];
	logic [3:0] bah_r [NUM_CH];
	logic [3:0] bah_nxt [NUM_CH];
	dcc_pkg::dcc_offset_t ao_r [NUM_CH];
	dcc_pkg::dcc_offset_t ao_nxt [NUM_CH];
	logic [2:0] sel_r, sel_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic full_r, full_nxt, mid_r, mid_nxt, done_r, done_nxt;

	logic pend_r, pend_nxt;
	logic [11:0] pend_addr_r, pend_addr_nxt;
	logic [1:0] pend_lane_r, pend_lane_nxt;
	logic [3:0] pend_route_r, pend_route_nxt;
	logic [1:0] lane_r, lane_nxt, slane_r, slane_nxt;
	logic rd_r, rd_nxt, from_ram_r, from_ram_nxt;
	logic [11:0] saddr_r, saddr_nxt;
	logic [3:0] sroute_r, sroute_nxt;
	logic hv_r, hv_nxt, sv_r, sv_nxt;
	logic [7:0] hd_r, hd_nxt, sd_r, sd_nxt;
	logic [11:0] ha_r, ha_nxt, sa_r, sa_nxt;
	logic [1:0] hl_r, hl_nxt, sl_r, sl_nxt;
	logic [3:0] hr_r, hr_nxt, sr_r, sr_nxt;
	logic stall_r, stall_nxt;

	logic ch_ok, sel_ok, go, at_end;
	logic [7:0] act_cfg;
	logic [3:0] act_route;
	logic [2:0] occ;
	dcc_pkg::dcc_offset_t act_ao, ao_inc;

	// only codes below the channel count are live
	assign sel_ok = sel_r != `DCC_CHSEL_INVALID && 32'(sel_r) < NUM_CH;
	assign ch_ok = act_ch != `DCC_CHSEL_INVALID && 32'(act_ch) < NUM_CH;
	assign act_cfg = ch_ok ? cfg_r[act_ch] : `DCC_RESET_BYTE;
	assign act_ao = ch_ok ? ao_r[act_ch] : '0;
	assign act_route = act_cfg[`DCC_CFG_ROUTE_MSB:0];
	assign ao_inc = act_ao + 10'h001;
	assign at_end = act_ao == act_size;
	// bytes in flight count too: data returns one cycle after src_rd
	assign occ = 3'(hv_r) + 3'(sv_r) + 3'(pend_r) + 3'(rd_r);
	// stall blocks new bytes; bad route moves nothing
	assign go = act_busy && ch_ok && !act_cfg[`DCC_CFG_STALL_BIT] &&
		act_route <= dcc_pkg::DCC_AES_OUT_TO_RAM && !at_end && occ < 3'h2;

	// register file and offset counters
	always_comb begin
		cfg_nxt = cfg_r;
		bal_nxt = bal_r;
		bah_nxt = bah_r;
		ao_nxt = ao_r;
		sel_nxt = sel_r;
		rdata_nxt = rdata_r;
		full_nxt = 1'b0;
		mid_nxt = 1'b0;
		done_nxt = 1'b0;
		if (go) begin
			ao_nxt[act_ch] = ao_inc;
			if (ao_inc == act_size) begin
				full_nxt = act_cfg[`DCC_CFG_FULL_IE_BIT];
				done_nxt = 1'b1;
				if (act_wrap) begin
					ao_nxt[act_ch] = '0;
				end
			end
			if (ao_inc == (act_size >> 1) && act_size > 10'h001) begin
				mid_nxt = act_cfg[`DCC_CFG_MID_IE_BIT];
			end
		end
		if (sfr_rd) begin
			rdata_nxt = `DCC_RESET_BYTE;
			unique case (sfr_addr)
				`DCC_SFR_CHANNEL_SELECT: rdata_nxt = {5'h00, sel_r};
				// indirect reads see only the selected channel
				`DCC_SFR_CHANNEL_CONFIG: if (sel_ok) rdata_nxt = cfg_r[sel_r];
				`DCC_SFR_BASE_ADDRESS_LOW: if (sel_ok) rdata_nxt = bal_r[sel_r];
				`DCC_SFR_BASE_ADDRESS_HIGH:
					if (sel_ok) rdata_nxt = {4'h0, bah_r[sel_r]};
				`DCC_SFR_ADDRESS_OFFSET_LOW:
					if (sel_ok) rdata_nxt = ao_r[sel_r][7:0];
				`DCC_SFR_ADDRESS_OFFSET_HIGH:
					if (sel_ok) rdata_nxt = {6'h00, ao_r[sel_r][9:8]};
				default: rdata_nxt = `DCC_RESET_BYTE;
			endcase
		end
		// writes land in the selected channel only; firmware wins
		if (sfr_wr) begin
			if (sfr_addr == `DCC_SFR_CHANNEL_SELECT) begin
				sel_nxt = sfr_wdata[2:0];
			end else if (sel_ok) begin
				unique case (sfr_addr)
					// route code kept in bits 3:0
					`DCC_SFR_CHANNEL_CONFIG: cfg_nxt[sel_r] = sfr_wdata;
					`DCC_SFR_BASE_ADDRESS_LOW: bal_nxt[sel_r] = sfr_wdata;
					`DCC_SFR_BASE_ADDRESS_HIGH: bah_nxt[sel_r] = sfr_wdata[3:0];
					`DCC_SFR_ADDRESS_OFFSET_LOW: ao_nxt[sel_r][7:0] = sfr_wdata;
					`DCC_SFR_ADDRESS_OFFSET_HIGH:
						ao_nxt[sel_r][9:8] = sfr_wdata[1:0];
					default: sel_nxt = sel_r;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				cfg_r[i] <= `DCC_RESET_BYTE;
				bal_r[i] <= `DCC_RESET_BYTE;
				bah_r[i] <= 4'h0;
				ao_r[i] <= '0;
			end
			sel_r <= 3'h0;
			rdata_r <= `DCC_RESET_BYTE;
			full_r <= 1'b0;
			mid_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			cfg_r <= cfg_nxt;
			bal_r <= bal_nxt;
			bah_r <= bah_nxt;
			ao_r <= ao_nxt;
			sel_r <= sel_nxt;
			rdata_r <= rdata_nxt;
			full_r <= full_nxt;
			mid_r <= mid_nxt;
			done_r <= done_nxt;
		end
	end

	// byte mover: request, one-cycle return, two-entry buffer to sink
	always_comb begin
		rd_nxt = go;
		from_ram_nxt = from_ram_r;
		saddr_nxt = saddr_r;
		sroute_nxt = sroute_r;
		pend_nxt = rd_r;
		pend_addr_nxt = saddr_r;
		pend_lane_nxt = slane_r;
		pend_route_nxt = sroute_r;
		slane_nxt = slane_r;
		lane_nxt = act_busy ? lane_r : 2'h0;
		stall_nxt = ch_ok && act_busy && act_cfg[`DCC_CFG_STALL_BIT];
		hv_nxt = hv_r;
		hd_nxt = hd_r;
		ha_nxt = ha_r;
		hl_nxt = hl_r;
		hr_nxt = hr_r;
		sv_nxt = sv_r;
		sd_nxt = sd_r;
		sa_nxt = sa_r;
		sl_nxt = sl_r;
		sr_nxt = sr_r;
		if (go) begin
			from_ram_nxt = !route_to_ram(act_route);
			sroute_nxt = act_route;
			saddr_nxt = addr_of(bah_r[act_ch], bal_r[act_ch], act_ao);
			if (act_cfg[`DCC_CFG_ENDIAN_BIT]) begin
				slane_nxt = group_len(act_route) - 2'h1 - lane_r;
			end else begin
				slane_nxt = lane_r;
			end
			// single-byte routes stay on lane zero
			if (lane_r + 2'h1 >= group_len(act_route)) begin
				lane_nxt = 2'h0;
			end else begin
				lane_nxt = lane_r + 2'h1;
			end
		end
		if (hv_r && snk_ready) begin
			hv_nxt = sv_r;
			sv_nxt = 1'b0;
			hd_nxt = sd_r;
			ha_nxt = sa_r;
			hl_nxt = sl_r;
			hr_nxt = sr_r;
		end
		if (pend_r) begin
			if (!hv_nxt) begin
				hv_nxt = 1'b1;
				hd_nxt = src_data;
				ha_nxt = pend_addr_r;
				hl_nxt = pend_lane_r;
				hr_nxt = pend_route_r;
			end else begin
				sv_nxt = 1'b1;
				sd_nxt = src_data;
				sa_nxt = pend_addr_r;
				sl_nxt = pend_lane_r;
				sr_nxt = pend_route_r;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_r <= 1'b0;
			from_ram_r <= 1'b0;
			saddr_r <= 12'h000;
			sroute_r <= 4'h0;
			pend_r <= 1'b0;
			pend_addr_r <= 12'h000;
			pend_lane_r <= 2'h0;
			pend_route_r <= 4'h0;
			lane_r <= 2'h0;
			slane_r <= 2'h0;
			stall_r <= 1'b0;
			hv_r <= 1'b0;
			hd_r <= 8'h00;
			ha_r <= 12'h000;
			hl_r <= 2'h0;
			hr_r <= 4'h0;
			sv_r <= 1'b0;
			sd_r <= 8'h00;
			sa_r <= 12'h000;
			sl_r <= 2'h0;
			sr_r <= 4'h0;
		end else begin
			rd_r <= rd_nxt;
			from_ram_r <= from_ram_nxt;
			saddr_r <= saddr_nxt;
			sroute_r <= sroute_nxt;
			pend_r <= pend_nxt;
			pend_addr_r <= pend_addr_nxt;
			pend_lane_r <= pend_lane_nxt;
			pend_route_r <= pend_route_nxt;
			lane_r <= lane_nxt;
			slane_r <= slane_nxt;
			stall_r <= stall_nxt;
			hv_r <= hv_nxt;
			hd_r <= hd_nxt;
			ha_r <= ha_nxt;
			hl_r <= hl_nxt;
			hr_r <= hr_nxt;
			sv_r <= sv_nxt;
			sd_r <= sd_nxt;
			sa_r <= sa_nxt;
			sl_r <= sl_nxt;
			sr_r <= sr_nxt;
		end
	end

	assign sfr_rdata = rdata_r;
	assign src_rd = rd_r;
	assign src_from_ram = from_ram_r;
	assign src_addr = saddr_r;
	assign src_route = sroute_r;
	assign snk_valid = hv_r;
	assign snk_data = hd_r;
	assign snk_addr = ha_r;
	assign snk_lane = hl_r;
	assign snk_route = hr_r;
	assign snk_to_ram = route_to_ram(hr_r) ? 1'b1 : 1'b0;
	assign full_irq = full_r;
	assign mid_irq = mid_r;
	assign xfer_done = done_r;
	assign stalled = stall_r;

endmodule : dcc_channel_config
`default_nettype wire

// file: dcc_channel_config_regs.svh
// register addresses, field positions, reset values and timing counts
// assumes an 8-bit special-function-register bus with byte addresses
`ifndef DCC_CHANNEL_CONFIG_REGS_SVH
`define DCC_CHANNEL_CONFIG_REGS_SVH

`define DCC_SFR_CHANNEL_CONFIG 8'hc9
`define DCC_SFR_BASE_ADDRESS_LOW 8'hca
`define DCC_SFR_BASE_ADDRESS_HIGH 8'hcb
`define DCC_SFR_ADDRESS_OFFSET_LOW 8'hcc
`define DCC_SFR_ADDRESS_OFFSET_HIGH 8'hcd
`define DCC_SFR_CHANNEL_SELECT 8'hd1

`define DCC_CFG_FULL_IE_BIT 7
`define DCC_CFG_MID_IE_BIT 6
`define DCC_CFG_STALL_BIT 5
`define DCC_CFG_ENDIAN_BIT 4
`define DCC_CFG_ROUTE_MSB 3

`define DCC_RESET_BYTE 8'h00
`define DCC_CHSEL_INVALID 3'h7
`define DCC_ENCODER_BYTES 2'h3
`define DCC_SOURCE_LATENCY 1

`endif

// file: dcc_pkg.sv
// types shared by the channel configuration block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package dcc_pkg;
	typedef enum logic [3:0] {
		DCC_RAM_TO_ENC = 4'h0,
		DCC_ENC_TO_RAM = 4'h1,
		DCC_RAM_TO_CRC = 4'h2,
		DCC_RAM_TO_SPI = 4'h3,
		DCC_SPI_TO_RAM = 4'h4,
		DCC_RAM_TO_AES_KEY = 4'h5,
		DCC_RAM_TO_AES_BLOCK = 4'h6,
		DCC_RAM_TO_AES_XOR = 4'h7,
		DCC_AES_OUT_TO_RAM = 4'h8
	} dcc_route_e;
	typedef logic [11:0] dcc_addr_t;
	typedef logic [9:0] dcc_offset_t;
endpackage : dcc_pkg
`default_nettype wire

// file: dcc_channel_config_monitor.sv
// checker watching the ports of dcc_channel_config
// assumes one clock, ref_clk, and rst_n asynchronous active low
`default_nettype none
module dcc_channel_config_monitor #(
	parameter int NUM_CH = 7
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [2:0] act_ch,
	input wire logic act_busy,
	input wire logic src_rd,
	input wire logic [3:0] src_route,
	input wire logic snk_valid,
	input wire logic [7:0] snk_data,
	input wire logic [1:0] snk_lane,
	input wire logic [3:0] snk_route,
	input wire logic snk_to_ram,
	input wire logic snk_ready,
	input wire logic full_irq,
	input wire logic mid_irq,
	input wire logic xfer_done,
	input wire logic stalled
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence fetch_s;
		src_rd;
	endsequence
	sequence landed_s;
		##2 snk_valid;
	endsequence
	sequence stuck_s;
		snk_valid && !snk_ready;
	endsequence
	full_done_a: assert property (full_irq |-> xfer_done)
		else $error("full irq without completion");
	mid_point_a: assert property (mid_irq |-> src_rd && !full_irq)
		else $error("mid irq off its fetch");
	done_fetch_a: assert property (xfer_done |-> fetch_s)
		else $error("completion without fetch");
	fetch_land_a: assert property (fetch_s |-> landed_s)
		else $error("fetched byte not offered");
	offer_hold_a:
		assert property (stuck_s |=> snk_valid && $stable(snk_data))
		else $error("offered byte changed");
	stall_halt_a: assert property (stalled [*3] |-> !src_rd)
		else $error("fetch while stalled");
	busy_gate_a: assert property (src_rd |-> $past(act_busy))
		else $error("fetch while idle");
	chan_valid_a: assert property (src_rd |-> $past(act_ch) < NUM_CH)
		else $error("fetch for invalid channel");
	route_valid_a: assert property (src_rd |-> src_route <= 4'h8)
		else $error("fetch on undefined route");
	single_lane_a:
		assert property (snk_valid && snk_route > 4'h1 |-> snk_lane == 2'h0)
		else $error("lane set on one-byte route");
	sink_dir_a:
		assert property (snk_valid |->
			snk_to_ram == (snk_route inside {4'h1, 4'h4, 4'h8}))
		else $error("sink direction wrong");
endmodule // dcc_channel_config_monitor
bind dcc_channel_config dcc_channel_config_monitor #(.NUM_CH(NUM_CH)) mon (
	.ref_clk, .rst_n, .act_ch, .act_busy, .src_rd, .src_route, .snk_valid,
	.snk_data, .snk_lane, .snk_route, .snk_to_ram, .snk_ready, .full_irq,
	.mid_irq, .xfer_done, .stalled);
`default_nettype wire

// file: dcc_partner.sv
// byte source and sink standing beyond the transfer block
// assumes fetched data is wanted exactly one clock after src_rd
`default_nettype none
module dcc_partner (
	input wire logic ref_clk,
	input wire logic src_rd,
	input wire logic src_from_ram,
	input wire logic [11:0] src_addr,
	input wire logic [3:0] src_route,
	input wire logic slow,
	input wire logic [7:0] rnd,
	output logic [7:0] src_data,
	output logic snk_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] word;
	assign word = src_from_ram ? src_addr[7:0] ^ 8'h5a : {4'ha, src_route};
	assign snk_ready = !slow || rnd[0];
	initial src_data = 8'h00;
	// stale data is inverted so it never looks held
	always @(posedge ref_clk) begin
		if (src_rd)
			src_data <= word;
		else
			src_data <= ~src_data;
	end
endmodule // dcc_partner
`default_nettype wire

// file: dcc_channel_config_bench.sv
// self-checking bench for dcc_channel_config
// assumes dcc_partner as source and sink, one 100 MHz clock
`default_nettype none
module dcc_channel_config_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
	logic sfr_wr = 1'b0, sfr_rd = 1'b0, act_busy = 1'b0, act_wrap = 1'b0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, rnd = 8'h00;
	logic [2:0] act_ch = 3'h0;
	logic [9:0] act_size = 10'h000;
	logic [7:0] sfr_rdata, src_data, snk_data;
	logic [11:0] src_addr, snk_addr;
	logic [3:0] src_route, snk_route;
	logic [1:0] snk_lane;
	logic src_rd, src_from_ram, snk_valid, snk_to_ram, snk_ready;
	logic full_irq, mid_irq, xfer_done, stalled, rd_d;
	logic [7:0] rq[$];
	logic [9:0] sq[$];
	logic [7:0] regs[5] = '{8'hc9, 8'hca, 8'hcb, 8'hcd, 8'h80};
	int bad_count = 0, cmp_count = 0, full_n = 0, mid_n = 0;
	dcc_channel_config DUT (.ref_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
		.sfr_wdata, .sfr_rdata, .act_ch, .act_busy, .act_size, .act_wrap,
		.src_rd, .src_from_ram, .src_addr, .src_route, .src_data,
		.snk_valid, .snk_data, .snk_addr, .snk_lane, .snk_route,
		.snk_to_ram, .snk_ready, .full_irq, .mid_irq, .xfer_done, .stalled);
	dcc_partner far (.ref_clk, .src_rd, .src_from_ram, .src_addr,
		.src_route, .slow, .rnd, .src_data, .snk_ready);
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) #1 rnd = 8'($urandom);
	task automatic chk(input string n, input logic [9:0] e,
		input logic [9:0] s);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// outputs are read at the edge, before its updates land
	always @(posedge ref_clk) begin
		rd_d <= sfr_rd && rst_n;
		full_n += int'(full_irq);
		mid_n += int'(mid_irq);
		if (rd_d)
			chk("rdata", rq.pop_front(), sfr_rdata);
		if (rst_n && snk_valid && snk_ready)
			chk("sink", sq.size() ? sq.pop_front() : 10'h3ff,
				{snk_lane, snk_data});
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge ref_clk) #1 sfr_wr = 1'b0;
		@(posedge ref_clk) #1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge ref_clk) #1 sfr_rd = 1'b0;
		@(posedge ref_clk) #1;
	endtask
	function automatic logic [1:0] lane(input logic [7:0] c, input int i);
		if (c[3:0] > 4'h1)
			return 2'h0;
		return c[4] ? 2'(2 - i % 3) : 2'(i % 3);
	endfunction
	task automatic xfer(input logic [2:0] ch, input logic [7:0] cfg,
		input logic [11:0] base, input logic [9:0] n);
		logic [11:0] a;
		logic ok;
		int f0, m0;
		ok = cfg[3:0] < 4'h9;
		wr(8'hd1, {5'h00, ch});
		wr(8'hc9, cfg);
		wr(8'hca, base[7:0]);
		wr(8'hcb, {4'h0, base[11:8]});
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		for (int i = 0; i < n && ok; i++) begin
			a = base + 12'(i);
			sq.push_back({lane(cfg, i), cfg[3:0] inside {1, 4, 8} ?
				{4'ha, cfg[3:0]} : a[7:0] ^ 8'h5a});
		end
		f0 = full_n;
		m0 = mid_n;
		act_ch = ch;
		act_size = n;
		act_busy = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1;
		if (cfg[5]) begin
			chk("stalled", 10'h001, stalled);
			chk("held", n, 10'(sq.size()));
			wr(8'hc9, cfg & 8'hdf);
		end
		for (int k = 0; k < 300 && sq.size() > 0; k++)
			@(posedge ref_clk);
		#1 act_busy = 1'b0;
		chk("drained", 10'h000, 10'(sq.size()));
		chk("full", cfg[7] && ok, 10'(full_n - f0));
		chk("mid", cfg[6] && n > 1 && ok, 10'(mid_n - m0));
		rd(8'hcc, ok ? n[7:0] : 8'h00);
	endtask
	initial begin
		#50000;
		bad_count++;
		end_of_test;
	end
	initial begin
		void'($urandom(61));
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		wr(8'hd1, 8'h02);
		wr(8'hc9, 8'hd2);
		wr(8'hcb, 8'hf5);
		wr(8'hcd, 8'hff);
		wr(8'h80, 8'hff);
		rd(8'hc9, 8'hd2);
		rd(8'hcb, 8'h05);
		rd(8'hcd, 8'h03);
		rd(8'h80, 8'h00);
		wr(8'hd1, 8'h03);
		rd(8'hc9, 8'h00);
		wr(8'hd1, 8'h07);
		wr(8'hc9, 8'hff);
		rd(8'hc9, 8'h00);
		wr(8'hd1, 8'h02);
		rd(8'hc9, 8'hd2);
		for (int r = 0; r < 10; r++) begin
			slow = 1'(r);
			xfer(3'(r % 7), {2'($urandom_range(3)), 1'b0,
				1'($urandom_range(1)), 4'(r)}, 12'($urandom_range(4000)),
				r < 2 ? 10'd6 : 10'($urandom_range(8, 1)));
		end
		xfer(3'h5, 8'he3, 12'h0ff, 10'h004);
		end_of_test;
	end
endmodule // dcc_channel_config_bench
`default_nettype wire
